//--- hdl/dac_cfg_consts.vh
`ifndef DAC_CFG_CONSTS_VH
`define DAC_CFG_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_PAGE_SEL 10'h008
`define IDX_DLL_STATUS 10'h0C3
`define IDX_DLY_APPLY 10'h0DB
`define IDX_DIG_HOLD 10'h100
`define IDX_LINK_MODE 10'h110
`define IDX_INTERP 10'h111
`define IDX_MOD_CFG 10'h112
`define IDX_IRQ_STATUS 10'h1F0
`define IDX_IRQ_MASK 10'h1F1

// reset values
`define RST_PAGE_SEL 2'h3
`define RST_DLY_APPLY 1'h0
`define RST_DIG_HOLD 1'h1
`define RST_LINK_MODE 6'h20
`define RST_COMBINE 1'h0
`define RST_MAIN_INTERP 4'h1
`define RST_CH_INTERP 4'h4
`define RST_MOD_MODE 2'h0
`define RST_IRQ_MASK 4'h0

// field positions
`define POS_BAD_COMBO 7
`define POS_COMBINE 6
`define POS_LINK_DUAL 5
`define POS_MAIN_INTERP 4
`define POS_MOD_MODE 4

// modulator switch mode codes
`define MOD_I0_I1 2'h0
`define MOD_SUM_IQ 2'h1
`define MOD_I0_Q0 2'h2
`define MOD_SUM_I 2'h3

// interrupt status bit positions
`define EV_DLL_LOCK 0
`define EV_PLL_LOCK 1
`define EV_BAD_COMBO 2
`define EV_DLY_APPLY 3
`define NUM_EVENTS 4

`endif

//--- hdl/sync_two_flop.v
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for levels arriving from pins or other clocks
module sync_two_flop #(
   parameter W = 1
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] stable_q;

   // first stage feeds only the second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {W{1'b0}};
         stable_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         stable_q <= meta_q;
      end
   end

   assign sync_out = stable_q;
endmodule // sync_two_flop

`default_nettype wire

//--- hdl/dac_datapath_config_regs.v
// Functional notes
// - a zero-to-one write of the delay-line apply bit loads the delay line with the current delay settings.
// - while the digital-logic hold bit is 1 (its reset value) link digital, clock generation and datapath stay in reset.
// - a read-only status bit reads 1 once the delay-locked loop has locked.
// - bit 7 of the link mode register is a read-only flag for an unsupported mode and interpolation combination; the code flags only unlisted rate codes.
// - with bit 6 of the link mode register set in dual-link operation the two sync outputs are merged.
// - the six-bit link mode field selects single or dual link by its top bit and the configuration by the rest, reset 0x20.
// - main interpolation codes 0x1, 0x2, 0x4, 0x6, 0x8, 0xC give 1x, 2x, 4x, 6x, 8x, 12x.
// - channel interpolation codes 0x1, 0x2, 0x3, 0x4, 0x6, 0x8 give 1x to 8x, reset 0x4.
// - switch modes 00, 01, 10 route I0/I1, I0+I1/Q0+Q1 and I0/Q0 to the two converters.
// - switch mode 11 drives converter 0 with I0+I1 and converter 1 with zero.
// - each main datapath keeps its own switch mode, reached through the main-path page select bits.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg_consts.vh"

module dac_datapath_config_regs (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output wire pslverr,
   output wire [31:0] prdata,
   input wire dll_locked,
   input wire pll_locked,
   input wire link0_sync_n,
   input wire link1_sync_n,
   output wire sync_out0_n,
   output wire sync_out1_n,
   output wire delay_line_load,
   output wire serdes_digital_rst,
   output wire clock_gen_rst,
   output wire datapath_rst,
   output wire dual_link,
   output wire [4:0] link_config,
   output wire [3:0] main_interp_factor,
   output wire [3:0] channel_interp_factor,
   input wire [15:0] path0_i,
   input wire [15:0] path0_q,
   input wire [15:0] path1_i,
   input wire [15:0] path1_q,
   output wire [16:0] conv0_data,
   output wire [16:0] conv1_data,
   output wire irq
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg [1:0] main_path_page_select_q;
   reg dly_apply_q;
   reg dly_load_q;
   reg digital_logic_hold_bit_q;
   reg merged_sync_outputs_q;
   reg [5:0] link_mode_select_q;
   reg [3:0] main_interp_rate_q;
   reg [3:0] channel_interp_rate_q;
   reg [1:0] modulator_switch_mode_q [0:1];
   reg bad_combo_q;
   reg [3:0] main_factor_q;
   reg [3:0] ch_factor_q;
   reg [`NUM_EVENTS-1:0] irq_status_q;
   reg [`NUM_EVENTS-1:0] irq_mask_q;
   reg [31:0] prdata_q;
   reg dll_lock_prev_q;
   reg pll_lock_prev_q;
   reg bad_combo_prev_q;
   reg sync0_n_q;
   reg sync1_n_q;
   reg [16:0] conv0_q;
   reg [16:0] conv1_q;

   wire dll_lock_s;
   wire pll_lock_s;
   wire link0_sync_act;
   wire link1_sync_act;

   // lock flags and link sync lines come from other clock trees
   sync_two_flop #(
      .W(4)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({~link1_sync_n, ~link0_sync_n, pll_locked, dll_locked}), // sync enters active high: flop reset means idle
      .sync_out({link1_sync_act, link0_sync_act, pll_lock_s, dll_lock_s})
   );

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------

   // main interpolation code to factor; zero marks an unlisted code
   function [3:0] main_factor;
      input [3:0] code;
      begin
         case (code)
            4'h1: main_factor = 4'h1;
            4'h2: main_factor = 4'h2;
            4'h4: main_factor = 4'h4;
            4'h6: main_factor = 4'h6;
            4'h8: main_factor = 4'h8;
            4'hC: main_factor = 4'hC;
            default: main_factor = 4'h0;
         endcase
      end
   endfunction

   // channel interpolation code to factor; zero marks an unlisted code
   function [3:0] ch_factor;
      input [3:0] code;
      begin
         case (code)
            4'h1: ch_factor = 4'h1;
            4'h2: ch_factor = 4'h2;
            4'h3: ch_factor = 4'h3;
            4'h4: ch_factor = 4'h4;
            4'h6: ch_factor = 4'h6;
            4'h8: ch_factor = 4'h8;
            default: ch_factor = 4'h0;
         endcase
      end
   endfunction

   // converter routing for one switch mode; sel picks converter 0 or 1
   function [16:0] route;
      input [1:0] mode;
      input sel;
      input [15:0] i0;
      input [15:0] q0;
      input [15:0] i1;
      input [15:0] q1;
      reg [16:0] sum_i;
      reg [16:0] sum_q;
      begin
         sum_i = {i0[15], i0} + {i1[15], i1};
         sum_q = {q0[15], q0} + {q1[15], q1};
         case (mode)
            `MOD_I0_I1: route = sel ? {i1[15], i1} : {i0[15], i0};
            `MOD_SUM_IQ: route = sel ? sum_q : sum_i;
            `MOD_I0_Q0: route = sel ? {q0[15], q0} : {i0[15], i0};
            `MOD_SUM_I: route = sel ? 17'h00000 : sum_i;
            default: route = 17'h00000;
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // apb access decode
   // ---------------------------------------------------------------
   wire [9:0] idx = paddr[11:2];
   wire aligned = (paddr[1:0] == 2'h0);
   wire hit_page = aligned && (idx == `IDX_PAGE_SEL);
   wire hit_dll = aligned && (idx == `IDX_DLL_STATUS);
   wire hit_dly = aligned && (idx == `IDX_DLY_APPLY);
   wire hit_hold = aligned && (idx == `IDX_DIG_HOLD);
   wire hit_link = aligned && (idx == `IDX_LINK_MODE);
   wire hit_interp = aligned && (idx == `IDX_INTERP);
   wire hit_mod = aligned && (idx == `IDX_MOD_CFG);
   wire hit_ists = aligned && (idx == `IDX_IRQ_STATUS);
   wire hit_imask = aligned && (idx == `IDX_IRQ_MASK);
   wire mapped = hit_page | hit_dll | hit_dly | hit_hold | hit_link | hit_interp | hit_mod | hit_ists | hit_imask;

   wire setup_ph = psel && !penable;
   wire access_ph = psel && penable;
   // zero wait states: every access completes in its first access cycle
   assign pready = access_ph;
   assign pslverr = access_ph && !mapped;
   // only byte lane 0 carries register bits
   wire wr_en = access_ph && pwrite && mapped && pstrb[0];
   wire [7:0] wb = pwdata[7:0];

   // the lower page bit selects copy 0 whenever set, else copy 1
   wire page0 = main_path_page_select_q[0];
   wire [1:0] mode_view = page0 ? modulator_switch_mode_q[0] : modulator_switch_mode_q[1];

   // read mux, captured in the setup cycle so prdata comes from a flop
   reg [7:0] rd_byte;
   always @* begin
      rd_byte = 8'h00;
      case (1'b1)
         hit_page: rd_byte = {6'h00, main_path_page_select_q};
         hit_dll: rd_byte = {7'h00, dll_lock_s};
         hit_dly: rd_byte = {7'h00, dly_apply_q};
         hit_hold: rd_byte = {7'h00, digital_logic_hold_bit_q};
         hit_link: rd_byte = {bad_combo_q, merged_sync_outputs_q, link_mode_select_q};
         hit_interp: rd_byte = {main_interp_rate_q, channel_interp_rate_q};
         hit_mod: rd_byte = {2'h0, mode_view, 4'h0};
         hit_ists: rd_byte = {4'h0, irq_status_q};
         hit_imask: rd_byte = {4'h0, irq_mask_q};
         default: rd_byte = 8'h00;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (setup_ph && !pwrite) begin
         prdata_q <= {24'h000000, rd_byte};
      end
   end
   assign prdata = prdata_q;

   // ---------------------------------------------------------------
   // writable configuration
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_path_page_select_q <= `RST_PAGE_SEL;
         dly_apply_q <= `RST_DLY_APPLY;
         digital_logic_hold_bit_q <= `RST_DIG_HOLD;
         merged_sync_outputs_q <= `RST_COMBINE;
         link_mode_select_q <= `RST_LINK_MODE;
         main_interp_rate_q <= `RST_MAIN_INTERP;
         channel_interp_rate_q <= `RST_CH_INTERP;
         irq_mask_q <= `RST_IRQ_MASK;
      end else if (wr_en) begin
         if (hit_page) begin
            main_path_page_select_q <= wb[1:0];
         end
         if (hit_dly) begin
            dly_apply_q <= wb[0];
         end
         if (hit_hold) begin
            digital_logic_hold_bit_q <= wb[0];
         end
         if (hit_link) begin
            merged_sync_outputs_q <= wb[`POS_COMBINE];
            link_mode_select_q <= wb[5:0];
         end
         if (hit_interp) begin
            main_interp_rate_q <= wb[7:4];
            channel_interp_rate_q <= wb[3:0];
         end
         if (hit_imask) begin
            irq_mask_q <= wb[`NUM_EVENTS-1:0];
         end
      end
   end

   // paged switch mode; a write reaches every copy whose page bit is set
   genvar gp;
   generate
      for (gp = 0; gp < 2; gp = gp + 1) begin : g_mode
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               modulator_switch_mode_q[gp] <= `RST_MOD_MODE;
            end else if (wr_en && hit_mod && main_path_page_select_q[gp]) begin
               modulator_switch_mode_q[gp] <= wb[5:4];
            end
         end
      end
   endgenerate

   // one-cycle load strobe only on a zero-to-one write; rewriting 1 does nothing
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_load_q <= 1'b0;
      end else begin
         dly_load_q <= wr_en && hit_dly && wb[0] && !dly_apply_q;
      end
   end
   assign delay_line_load = dly_load_q;

   // ---------------------------------------------------------------
   // decoded rates and combination check
   // ---------------------------------------------------------------
   wire [3:0] main_f = main_factor(main_interp_rate_q);
   wire [3:0] ch_f = ch_factor(channel_interp_rate_q);

   // registered so the flag and factors change together one cycle after the write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bad_combo_q <= 1'b0;
         main_factor_q <= 4'h0;
         ch_factor_q <= 4'h0;
      end else begin
         bad_combo_q <= (main_f == 4'h0) || (ch_f == 4'h0);
         main_factor_q <= main_f;
         ch_factor_q <= ch_f;
      end
   end
   assign main_interp_factor = main_factor_q;
   assign channel_interp_factor = ch_factor_q;
   assign dual_link = link_mode_select_q[`POS_LINK_DUAL];
   assign link_config = link_mode_select_q[4:0];

   // ---------------------------------------------------------------
   // digital hold outputs
   // ---------------------------------------------------------------
   // the hold comes straight from its flop, so it is glitch-free
   assign serdes_digital_rst = digital_logic_hold_bit_q;
   assign clock_gen_rst = digital_logic_hold_bit_q;
   assign datapath_rst = digital_logic_hold_bit_q;

   // ---------------------------------------------------------------
   // sync output merging (active low: either link low pulls both low)
   // ---------------------------------------------------------------
   wire merge = merged_sync_outputs_q && dual_link;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync0_n_q <= 1'b1;
         sync1_n_q <= 1'b1;
      end else if (merge) begin
         sync0_n_q <= !(link0_sync_act | link1_sync_act);
         sync1_n_q <= !(link0_sync_act | link1_sync_act);
      end else begin
         sync0_n_q <= !link0_sync_act;
         sync1_n_q <= !link1_sync_act;
      end
   end
   assign sync_out0_n = sync0_n_q;
   assign sync_out1_n = sync1_n_q;

   // ---------------------------------------------------------------
   // converter routing; each converter follows its own path's mode
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv0_q <= 17'h00000;
         conv1_q <= 17'h00000;
      end else if (digital_logic_hold_bit_q) begin
         conv0_q <= 17'h00000;
         conv1_q <= 17'h00000;
      end else begin
         conv0_q <= route(modulator_switch_mode_q[0], 1'b0, path0_i, path0_q, path1_i, path1_q);
         conv1_q <= route(modulator_switch_mode_q[1], 1'b1, path0_i, path0_q, path1_i, path1_q);
      end
   end
   assign conv0_data = conv0_q;
   assign conv1_data = conv1_q;

   // ---------------------------------------------------------------
   // interrupts: sticky events, write one to clear, set wins over clear
   // ---------------------------------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dll_lock_prev_q <= 1'b0;
         pll_lock_prev_q <= 1'b0;
         bad_combo_prev_q <= 1'b0;
      end else begin
         dll_lock_prev_q <= dll_lock_s;
         pll_lock_prev_q <= pll_lock_s;
         bad_combo_prev_q <= bad_combo_q;
      end
   end

   // lock events tell software when the hold may be released
   wire [`NUM_EVENTS-1:0] events;
   assign events[`EV_DLL_LOCK] = dll_lock_s && !dll_lock_prev_q;
   assign events[`EV_PLL_LOCK] = pll_lock_s && !pll_lock_prev_q;
   assign events[`EV_BAD_COMBO] = bad_combo_q && !bad_combo_prev_q;
   assign events[`EV_DLY_APPLY] = dly_load_q;

   wire [`NUM_EVENTS-1:0] clr = (wr_en && hit_ists) ? wb[`NUM_EVENTS-1:0] : {`NUM_EVENTS{1'b0}};

   genvar ge;
   generate
      for (ge = 0; ge < `NUM_EVENTS; ge = ge + 1) begin : g_irq
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               irq_status_q[ge] <= 1'b0;
            end else if (events[ge]) begin
               irq_status_q[ge] <= 1'b1;
            end else if (clr[ge]) begin
               irq_status_q[ge] <= 1'b0;
            end
         end
      end
   endgenerate

   assign irq = |(irq_status_q & irq_mask_q);
endmodule // dac_datapath_config_regs

`default_nettype wire

//--- sim/cfg_regs_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level relations of the configuration bank
module cfg_regs_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready,
   input wire pslverr,
   input wire sync_out0_n,
   input wire sync_out1_n,
   input wire delay_line_load,
   input wire serdes_digital_rst,
   input wire clock_gen_rst,
   input wire datapath_rst,
   input wire dual_link,
   input wire [4:0] link_config,
   input wire [3:0] main_interp_factor,
   input wire [3:0] channel_interp_factor,
   input wire [16:0] conv0_data,
   input wire [16:0] conv1_data,
   input wire irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access phase and write qualifiers
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   ready_zero_wait_a: assert property (acc |-> pready) else $error("pready missing in access");
   err_in_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
   load_single_a: assert property (delay_line_load |=> !delay_line_load)
      else $error("delay load longer than one cycle");
   load_cause_a: assert property (delay_line_load |-> $past(wr))
      else $error("delay load without a write");
   rst_tied_a: assert property (serdes_digital_rst == datapath_rst && clock_gen_rst == datapath_rst)
      else $error("reset outputs disagree");
   hold_stable_a: assert property (!wr |=> $stable(datapath_rst))
      else $error("hold changed without a write");
   conv_held_a: assert property (datapath_rst && $past(datapath_rst) |-> conv0_data == 17'h00000 && conv1_data == 17'h00000)
      else $error("converter data while held");
   link_stable_a: assert property (!wr |=> $stable(dual_link) && $stable(link_config))
      else $error("link mode changed without a write");
   main_codes_a: assert property (main_interp_factor inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC})
      else $error("main factor not a listed rate");
   ch_codes_a: assert property (channel_interp_factor inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8})
      else $error("channel factor not a listed rate");
   cover property (delay_line_load);
   cover property (irq);
   cover property (!sync_out0_n && !sync_out1_n);
endmodule // cfg_regs_chk

bind dac_datapath_config_regs cfg_regs_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
   .sync_out0_n, .sync_out1_n, .delay_line_load, .serdes_digital_rst, .clock_gen_rst, .datapath_rst, .dual_link,
   .link_config, .main_interp_factor, .channel_interp_factor, .conv0_data, .conv1_data, .irq);
`default_nettype wire

//--- sim/tb_dac_datapath_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "dac_cfg_consts.vh"
module tb_dac_datapath_config_regs;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, main_interp_factor, channel_interp_factor;
   logic dll_locked, pll_locked, link0_sync_n, link1_sync_n, sync_out0_n, sync_out1_n, delay_line_load;
   logic serdes_digital_rst, clock_gen_rst, datapath_rst, dual_link;
   logic [4:0] link_config;
   logic [15:0] path0_i, path0_q, path1_i, path1_q;
   logic [16:0] conv0_data, conv1_data;
   int err_count, tests_run, loads, i;
   logic [9:0] ridx [9] = '{`IDX_PAGE_SEL, `IDX_DLL_STATUS, `IDX_DLY_APPLY, `IDX_DIG_HOLD, `IDX_LINK_MODE,
      `IDX_INTERP, `IDX_MOD_CFG, `IDX_IRQ_STATUS, `IDX_IRQ_MASK};
   logic [7:0] rrst [9] = '{8'h03, 8'h00, 8'h00, 8'h01, 8'h20, 8'h14, 8'h00, 8'h00, 8'h00};
   logic [3:0] mcode [6] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC};
   logic [3:0] ccode [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8};
   logic [16:0] e0 [4] = '{17'h00100, 17'h00103, 17'h00100, 17'h00103};
   logic [16:0] e1 [4] = '{17'h00003, 17'h04020, 17'h00020, 17'h00000};

   dac_datapath_config_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
      .pslverr, .prdata, .dll_locked, .pll_locked, .link0_sync_n, .link1_sync_n, .sync_out0_n, .sync_out1_n,
      .delay_line_load, .serdes_digital_rst, .clock_gen_rst, .datapath_rst, .dual_link, .link_config,
      .main_interp_factor, .channel_interp_factor, .path0_i, .path0_q, .path1_i, .path1_q, .conv0_data,
      .conv1_data, .irq);

   // 40 MHz clock
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // counts every high cycle of the load strobe
   always @(posedge pclk) begin
      if (delay_line_load === 1'b1) loads++;
   end

   task end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // apb transfer; request held until pready is sampled high, bounded so a hang ends the run
   task xfer(input logic w, input logic [9:0] idx, input logic [7:0] wd, input logic [3:0] st);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         err_count++;
         end_sim();
      end
   endtask

   task wr(input logic [9:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d, 4'hF);
   endtask

   task rchk(input logic [9:0] idx, input logic [7:0] e);
      xfer(1'b0, idx, 8'h00, 4'h0);
      check(rd, {24'h000000, e});
   endtask

   // lets the edge's updates land before sampling
   task settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {dll_locked, pll_locked, link0_sync_n, link1_sync_n} = 4'h3;
      path0_i = 16'h0100;
      path0_q = 16'h0020;
      path1_i = 16'h0003;
      path1_q = 16'h4000;
      {err_count, tests_run, loads} = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      settle(3);
      for (i = 0; i < 9; i++) rchk(ridx[i], rrst[i]);
      check({29'h0, serdes_digital_rst, clock_gen_rst, datapath_rst}, 32'h7);
      xfer(1'b0, 10'h3FF, 8'h00, 4'h0);
      check({er, rd[30:0]}, 32'h80000000);
      // read-only flag bit ignores the write; strobe-less write dropped
      wr(`IDX_LINK_MODE, 8'hFF);
      xfer(1'b1, `IDX_LINK_MODE, 8'h00, 4'h0);
      rchk(`IDX_LINK_MODE, 8'h7F);
      check({dual_link, link_config}, 32'h3F);
      link0_sync_n <= 1'b0;
      settle(5);
      check({sync_out0_n, sync_out1_n}, 32'h0);
      wr(`IDX_LINK_MODE, 8'h20);
      settle(5);
      check({sync_out0_n, sync_out1_n, dual_link, link_config}, 32'h60);
      wr(`IDX_IRQ_MASK, 8'h04);
      for (i = 0; i < 6; i++) begin
         wr(`IDX_INTERP, {mcode[i], ccode[5 - i]});
         settle(2);
         check({main_interp_factor, channel_interp_factor}, {mcode[i], ccode[5 - i]});
      end
      check(irq, 32'h0);
      // unlisted codes flag the combination and raise the interrupt
      wr(`IDX_INTERP, 8'h15);
      settle(2);
      check({main_interp_factor, channel_interp_factor, irq}, 32'h021);
      rchk(`IDX_LINK_MODE, 8'hA0);
      wr(`IDX_INTERP, 8'h17);
      settle(2);
      check({main_interp_factor, channel_interp_factor}, 32'h10);
      wr(`IDX_INTERP, 8'h14);
      wr(`IDX_IRQ_MASK, 8'h00);
      settle(1);
      check(irq, 32'h0);
      wr(`IDX_IRQ_MASK, 8'h04);
      settle(1);
      check(irq, 32'h1);
      rchk(`IDX_IRQ_STATUS, 8'h04);
      wr(`IDX_IRQ_STATUS, 8'h04);
      settle(1);
      check(irq, 32'h0);
      rchk(`IDX_IRQ_STATUS, 8'h00);
      wr(`IDX_IRQ_MASK, 8'h00);
      // apply writes 1,1,0,1 give one pulse only on each rise
      for (i = 0; i < 4; i++) begin
         loads = 0;
         wr(`IDX_DLY_APPLY, {7'h00, i != 2});
         settle(3);
         check(loads, {31'h0, i == 0 || i == 3});
      end
      @(posedge pclk);
      dll_locked <= 1'b1;
      pll_locked <= 1'b1;
      settle(4);
      rchk(`IDX_DLL_STATUS, 8'h01);
      rchk(`IDX_IRQ_STATUS, 8'h0B);
      wr(`IDX_DIG_HOLD, 8'h00);
      settle(2);
      check({serdes_digital_rst, clock_gen_rst, datapath_rst}, 32'h0);
      // both pages selected: every switch mode on both converters
      for (i = 0; i < 4; i++) begin
         wr(`IDX_MOD_CFG, {2'b00, i[1:0], 4'h0});
         settle(3);
         check({conv0_data, 15'h0000}, {e0[i], 15'h0000});
         check(conv1_data, e1[i]);
      end
      wr(`IDX_PAGE_SEL, 8'h01);
      wr(`IDX_MOD_CFG, 8'h20);
      wr(`IDX_PAGE_SEL, 8'h02);
      wr(`IDX_MOD_CFG, 8'h10);
      settle(3);
      check({conv0_data, 15'h0000}, {17'h00100, 15'h0000});
      check(conv1_data, 17'h04020);
      rchk(`IDX_MOD_CFG, 8'h10);
      wr(`IDX_PAGE_SEL, 8'h01);
      rchk(`IDX_MOD_CFG, 8'h20);
      wr(`IDX_DIG_HOLD, 8'h01);
      settle(3);
      check({14'h0000, conv0_data | conv1_data, datapath_rst}, 32'h1);
      end_sim();
   end
endmodule // tb_dac_datapath_config_regs
`default_nettype wire
